// ### logic/mebs_swapper.sv
// Byte-order conversion between the media units and the 32-bit data highway.
// Assumes synchronous inputs on clk; one word per cycle, no back-pressure.
// Assumes software keeps every unit's order bit equal to the global byte order.
//
// Notes on behaviour
// - Swap only in big endian; little passes.
// - Image input: planar none, RGB24A full, YUV422A/RGB15A half.
// - Image output: 8-bit none, 16-bit half, RGB24A full.
// - Packed RGB24 only little endian, lanes upward.
// - Video input stores planar YUV, raw 8/10.
// - Video output takes planar and packed overlay.
// - Audio 8/16/32-bit samples, S/PDIF 32-bit words.
// - Audio moves whole bytes, bits untouched.
// - Audio samples ascend; 16-bit order per mode.
// - Decoder input bytes never reordered.
// - Decoder output words fully swapped in big.
// - Reset leaves every unit in big endian.
`timescale 1ns/100ps
module mebs_swapper (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Byte-order settings from software, one per unit
  input  wire mebs_pkg::mebs_order_s order_in,
  input  wire logic                  order_load,
  // Word from a unit or the highway
  input  wire logic                  in_valid,
  input  wire mebs_pkg::mebs_word_s  in_word,
  // Converted word
  output logic                       out_valid,
  output logic [31:0]                out_data,
  // Status
  output mebs_pkg::mebs_order_s      order_state,
  output logic                       fmt_error
);

  // Elaboration checks: the lane map and the status width are fixed by the package
  if (mebs_pkg::WORD_W != 32) begin : g_bad_word
    $error("mebs_swapper serves 32-bit words only");
  end
  if (mebs_pkg::LANES * 8 != mebs_pkg::WORD_W) begin : g_bad_lanes
    $error("mebs_swapper needs one byte per lane");
  end
  if (mebs_pkg::LATENCY != 1) begin : g_bad_latency
    $error("mebs_swapper has exactly one register stage");
  end
  if ($bits(mebs_pkg::mebs_order_s) != 7) begin : g_bad_order
    $error("mebs_swapper expects one order bit per unit");
  end

  // Decode of the word now at the inputs
  mebs_pkg::mebs_swap_e next_kind;
  logic                 next_bad;
  logic                 little;

  // Settings held here so reset alone gives big endian everywhere
  // Reset outranks a load in the same cycle, so a stray load cannot survive it
  always_ff @(posedge clk) begin
    if (srst) begin
      order_state <= '{default: mebs_pkg::ORDER_RESET};
    end else if (order_load) begin
      order_state <= order_in;
    end
  end

  // Pick the unit's own order bit
  // Both image directions share one bit; decoder and stray codes use the decoder's
  always_comb begin
    unique case (in_word.unit)
      mebs_pkg::MEBS_U_ICP_IN, mebs_pkg::MEBS_U_ICP_OUT: little = order_state.image_coprocessor;
      mebs_pkg::MEBS_U_VI:   little = order_state.vi;
      mebs_pkg::MEBS_U_VO:   little = order_state.vo;
      mebs_pkg::MEBS_U_AI:   little = order_state.ai;
      mebs_pkg::MEBS_U_AO:   little = order_state.ao;
      mebs_pkg::MEBS_U_SPDIF_OUTPUT_UNIT: little = order_state.spdif_output_unit;
      default:               little = order_state.vld;
    endcase
  end

  // Swap kind per unit and format; unsupported pairs flag and pass unchanged
  // Trade-off: a refused word still moves, so a bad setting never stalls the highway
  always_comb begin
    next_kind = mebs_pkg::MEBS_SWAP_NONE;
    next_bad  = 1'b0;
    unique case (in_word.unit)
      // Image input: 24-bit pixels turn whole words, 16-bit pixels turn halves
      mebs_pkg::MEBS_U_ICP_IN: begin
        unique case (in_word.fmt)
          mebs_pkg::MEBS_F_PLANAR:  next_kind = mebs_pkg::MEBS_SWAP_NONE;
          mebs_pkg::MEBS_F_RGB24A:  next_kind = mebs_pkg::MEBS_SWAP_FULL;
          mebs_pkg::MEBS_F_YUV422A,
          mebs_pkg::MEBS_F_RGB15A:  next_kind = mebs_pkg::MEBS_SWAP_HALF;
          default:                  next_bad  = 1'b1;
        endcase
      end

      // Image output: 8-bit pixels are byte streams and never move
      // Packed RGB24 crosses word edges, so no lane swap can serve big endian
      mebs_pkg::MEBS_U_ICP_OUT: begin
        unique case (in_word.fmt)
          mebs_pkg::MEBS_F_RGB8_233,
          mebs_pkg::MEBS_F_RGB8_332: next_kind = mebs_pkg::MEBS_SWAP_NONE;
          mebs_pkg::MEBS_F_RGB15A,
          mebs_pkg::MEBS_F_RGB16,
          mebs_pkg::MEBS_F_YUV422P:  next_kind = mebs_pkg::MEBS_SWAP_HALF;
          mebs_pkg::MEBS_F_RGB24A:   next_kind = mebs_pkg::MEBS_SWAP_FULL;
          mebs_pkg::MEBS_F_RGB24P:   next_bad  = ~little;  // Lanes already B,G,R upward
          default:                   next_bad  = 1'b1;
        endcase
      end

      // Video input: capture formats only
      mebs_pkg::MEBS_U_VI: begin
        // Planar and raw images are byte streams
        unique case (in_word.fmt)
          mebs_pkg::MEBS_F_PLANAR,
          mebs_pkg::MEBS_F_RAW8,
          mebs_pkg::MEBS_F_RAW10:   next_kind = mebs_pkg::MEBS_SWAP_NONE;
          default:                  next_bad  = 1'b1;
        endcase
      end

      // Video output: overlay pixels are 16-bit pairs like the packed image YUV
      mebs_pkg::MEBS_U_VO: begin
        unique case (in_word.fmt)
          mebs_pkg::MEBS_F_PLANAR:  next_kind = mebs_pkg::MEBS_SWAP_NONE;
          mebs_pkg::MEBS_F_YUV422A: next_kind = mebs_pkg::MEBS_SWAP_HALF;
          default:                  next_bad  = 1'b1;
        endcase
      end

      // Audio input: stereo pairs already put left before right
      mebs_pkg::MEBS_U_AI: begin
        // 8-bit samples already ascend by lane; 16-bit need MSB at lower lane
        unique case (in_word.fmt)
          mebs_pkg::MEBS_F_AUD8:    next_kind = mebs_pkg::MEBS_SWAP_NONE;
          mebs_pkg::MEBS_F_AUD16:   next_kind = mebs_pkg::MEBS_SWAP_HALF;
          default:                  next_bad  = 1'b1;
        endcase
      end

      // Audio output: 16-bit samples turn halves, 32-bit samples whole words
      mebs_pkg::MEBS_U_AO: begin
        unique case (in_word.fmt)
          mebs_pkg::MEBS_F_AUD16:   next_kind = mebs_pkg::MEBS_SWAP_HALF;
          mebs_pkg::MEBS_F_AUD32:   next_kind = mebs_pkg::MEBS_SWAP_FULL;
          default:                  next_bad  = 1'b1;
        endcase
      end

      // S/PDIF output: whole 32-bit words only
      mebs_pkg::MEBS_U_SPDIF_OUTPUT_UNIT: begin
        if (in_word.fmt == mebs_pkg::MEBS_F_AUD32) begin
          next_kind = mebs_pkg::MEBS_SWAP_FULL;
        end else begin
          next_bad  = 1'b1;
        end
      end

      // Decoder input: the format field is ignored, the stream is plain bytes
      // Its start address is byte aligned, so any lane move would scramble it
      mebs_pkg::MEBS_U_VLD_IN: begin
        next_kind = mebs_pkg::MEBS_SWAP_NONE;  // Bitstream stays byte ordered
      end

      // Decoder output: header and run-level words are read by the processor as words
      mebs_pkg::MEBS_U_VLD_OUT: begin
        next_kind = mebs_pkg::MEBS_SWAP_FULL;  // Undo the processor's word read swap
      end

      // Unit codes outside the list are flagged and left alone
      default: next_bad = 1'b1;
    endcase
    // Little endian passes every word untouched; an unsupported pair is never mangled
    if (little || next_bad) begin
      next_kind = mebs_pkg::MEBS_SWAP_NONE;
    end
  end

  // Error flag lines up with the registered word
  // Qualified by valid so idle cycles never report a bad pair
  always_ff @(posedge clk) begin
    if (srst) begin
      fmt_error <= 1'b0;
    end else begin
      fmt_error <= in_valid & next_bad;
    end
  end

  // Lane permutation and the output register for data and valid
  mebs_lane_swap #(
    .WIDTH (32)
  ) u_swap (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (in_valid),
    .kind      (next_kind),
    .in_data   (in_word.data),
    .out_valid (out_valid),
    .out_data  (out_data)
  );

endmodule : mebs_swapper

// ### shared/mebs_pkg.sv
// Shared types and constants for the media byte-order swapper.
// Assumes one 125 MHz clock and a synchronous active-high reset.
package mebs_pkg;

  // Byte-order setting: 0 selects big endian, 1 little endian
  localparam logic ORDER_BIG    = 1'b0;
  localparam logic ORDER_LITTLE = 1'b1;
  localparam logic ORDER_RESET  = ORDER_BIG;

  // Word geometry
  localparam int WORD_W = 32;
  localparam int LANES  = 4;

  // Pipeline latency of one word through the swapper, in cycles
  localparam int LATENCY = 1;

  // Swap kinds
  typedef enum logic [1:0] {
    MEBS_SWAP_NONE = 2'b00,
    MEBS_SWAP_HALF = 2'b01,
    MEBS_SWAP_FULL = 2'b10
  } mebs_swap_e;

  // Media unit selector carried with each word
  typedef enum logic [3:0] {
    MEBS_U_ICP_IN  = 4'h0,
    MEBS_U_ICP_OUT = 4'h1,
    MEBS_U_VI      = 4'h2,
    MEBS_U_VO      = 4'h3,
    MEBS_U_AI      = 4'h4,
    MEBS_U_AO      = 4'h5,
    MEBS_U_SPDIF_OUTPUT_UNIT    = 4'h6,
    MEBS_U_VLD_IN  = 4'h7,
    MEBS_U_VLD_OUT = 4'h8
  } mebs_unit_e;

  // Pixel / sample formats
  typedef enum logic [3:0] {
    MEBS_F_PLANAR    = 4'h0,
    MEBS_F_RGB24A    = 4'h1,
    MEBS_F_YUV422A   = 4'h2,
    MEBS_F_RGB15A    = 4'h3,
    MEBS_F_RGB8_233  = 4'h4,
    MEBS_F_RGB8_332  = 4'h5,
    MEBS_F_RGB16     = 4'h6,
    MEBS_F_RGB24P    = 4'h7,
    MEBS_F_YUV422P   = 4'h8,
    MEBS_F_RAW8      = 4'h9,
    MEBS_F_RAW10     = 4'hA,
    MEBS_F_AUD8      = 4'hB,
    MEBS_F_AUD16     = 4'hC,
    MEBS_F_AUD32     = 4'hD,
    MEBS_F_VLD_BYTES = 4'hE,
    MEBS_F_VLD_WORDS = 4'hF
  } mebs_fmt_e;

  // Per-unit byte-order bits, as software programs them
  typedef struct packed {
    logic image_coprocessor;
    logic vi;
    logic vo;
    logic ai;
    logic ao;
    logic spdif_output_unit;
    logic vld;
  } mebs_order_s;

  // One word on its way to or from the highway
  typedef struct packed {
    mebs_unit_e           unit;
    mebs_fmt_e            fmt;
    logic [WORD_W-1:0]    data;
  } mebs_word_s;

endpackage : mebs_pkg

// ### logic/mebs_lane_swap.sv
// Byte-lane permutation of one 32-bit word, registered output.
// Assumes the caller has already picked the swap kind.
`timescale 1ns/100ps
module mebs_lane_swap #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // Word in
  input  wire logic               in_valid,
  input  wire mebs_pkg::mebs_swap_e kind,
  input  wire logic [WIDTH-1:0]   in_data,
  // Word out
  output logic                    out_valid,
  output logic [WIDTH-1:0]        out_data
);

  // Elaboration check: the permutation below is written for four byte lanes
  if (WIDTH != 32) begin : g_bad_width
    $error("mebs_lane_swap serves 32-bit words only");
  end

  // Only whole bytes move; bits inside a byte keep their order
  function automatic logic [31:0] permute(input mebs_pkg::mebs_swap_e k, input logic [31:0] w);
    unique case (k)
      mebs_pkg::MEBS_SWAP_HALF: permute = {w[23:16], w[31:24], w[7:0], w[15:8]};
      mebs_pkg::MEBS_SWAP_FULL: permute = {w[7:0], w[15:8], w[23:16], w[31:24]};
      default:                  permute = w;
    endcase
  endfunction : permute

  // Register the result so data leaves from flip-flops
  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_data  <= 32'h0000_0000;
    end else begin
      out_valid <= in_valid;
      out_data  <= permute(kind, in_data);
    end
  end

endmodule : mebs_lane_swap

// ### tb/mebs_swapper_chk.sv
// Port checker for the media byte-order swapper.
// Assumes one clock domain; bound into every swapper instance.
`timescale 1ns/100ps
module mebs_swapper_chk (
  // Watched ports
  input wire logic                  clk,
  input wire logic                  srst,
  input wire mebs_pkg::mebs_order_s order_in,
  input wire logic                  order_load,
  input wire logic                  in_valid,
  input wire mebs_pkg::mebs_word_s  in_word,
  input wire logic                  out_valid,
  input wire logic [31:0]           out_data,
  input wire mebs_pkg::mebs_order_s order_state,
  input wire logic                  fmt_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Decoder output words; the simplest unit to check end to end
  logic vldo;
  assign vldo = in_valid && in_word.unit == mebs_pkg::MEBS_U_VLD_OUT;
  a_word_answer: assert property (in_valid |=> out_valid) else $error("word not answered");
  a_no_extra: assert property (!in_valid |=> !out_valid) else $error("spurious word");
  a_little_pass: assert property (vldo && order_state.vld |=> out_data == $past(in_word.data))
    else $error("little word altered");
  a_decoder_swap: assert property (vldo && !order_state.vld |=> out_data ==
    {$past(in_word.data[7:0]), $past(in_word.data[15:8]), $past(in_word.data[23:16]),
     $past(in_word.data[31:24])}) else $error("decoder word not swapped");
  a_input_bytes: assert property (in_valid && in_word.unit == mebs_pkg::MEBS_U_VLD_IN
    |=> out_data == $past(in_word.data)) else $error("decoder input reordered");
  a_packed_err: assert property (in_valid && in_word.unit == mebs_pkg::MEBS_U_ICP_OUT &&
    in_word.fmt == mebs_pkg::MEBS_F_RGB24P && !order_state.image_coprocessor |=> fmt_error) else $error("packed big");
  a_reset_big: assert property ($fell(srst) |-> order_state == 7'h00) else $error("not big after reset");
  a_order_load: assert property (order_load |=> order_state == $past(order_in)) else $error("order not loaded");
  a_order_hold: assert property (!order_load |=> $stable(order_state)) else $error("order drifted");
  c_big_decoder: cover property (vldo && !order_state.vld);
  c_little_decoder: cover property (vldo && order_state.vld);
  c_format_error: cover property (fmt_error);
endmodule : mebs_swapper_chk

bind mebs_swapper mebs_swapper_chk u_chk (.clk, .srst, .order_in, .order_load, .in_valid, .in_word,
  .out_valid, .out_data, .order_state, .fmt_error);

// ### tb/mebs_hwy_sink.sv
// Highway-side sink: stores each converted word one cycle later.
// Assumes the swapper's outputs; the highway never stalls.
`timescale 1ns/100ps
module mebs_hwy_sink (
  // Swapper side
  input  wire logic        clk,
  input  wire logic        out_valid,
  input  wire logic [31:0] out_data,
  input  wire logic        fmt_error,
  // Bench side
  output logic             got,
  output logic [32:0]      got_word
);
  // Memory write stage, kept with its error flag
  always_ff @(posedge clk) begin
    got      <= out_valid;
    got_word <= {fmt_error, out_data};
  end
endmodule : mebs_hwy_sink

// ### tb/test_media_endian_byte_swapper.sv
// Self-checking bench for the media byte-order swapper.
// Assumes a one-cycle answer and the highway sink model.
`timescale 1ns/100ps
module test_media_endian_byte_swapper;
  logic                  clk = 1'b0, srst = 1'b1, order_load = 1'b0, in_valid = 1'b0;
  mebs_pkg::mebs_order_s order_in = 7'h00, order_state, o;
  mebs_pkg::mebs_word_s  in_word = 40'h00_0000_0000;
  logic                  out_valid, fmt_error, got;
  logic [31:0]           out_data, d;
  logic [32:0]           got_word, exp, q[$];
  int                    miscompares = 0, n_checks = 0, cycles = 0, seed = 54541;
  // Unit, format and big endian kind: 0 none, 1 half, 2 full, 3 error
  logic [11:0] tbl [25] = '{12'h000, 12'h012, 12'h021, 12'h031, 12'h140, 12'h150, 12'h131, 12'h161,
    12'h181, 12'h112, 12'h173, 12'h200, 12'h290, 12'h2a0, 12'h300, 12'h321, 12'h4b0, 12'h4c1,
    12'h5c1, 12'h5d2, 12'h6d2, 12'h7e0, 12'h8f2, 12'h263, 12'h9d3};
  mebs_swapper dut_u (.clk, .srst, .order_in, .order_load, .in_valid, .in_word, .out_valid, .out_data,
    .order_state, .fmt_error);
  mebs_hwy_sink hwy_u (.clk, .out_valid, .out_data, .fmt_error, .got, .got_word);
  // Clock, 8 ns period
  initial forever #4 clk = ~clk;
  task automatic check(string what, logic [32:0] seen, logic [32:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task give_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // Expected word; packed RGB24 is an error only in big endian
  function automatic logic [32:0] expv(logic [11:0] t, mebs_pkg::mebs_order_s ob, logic [31:0] w);
    logic lit;
    lit = (t[11:8] < 4'h2) ? ob.image_coprocessor : (t[11:8] == 4'h2) ? ob.vi : (t[11:8] == 4'h3) ? ob.vo :
      (t[11:8] == 4'h4) ? ob.ai : (t[11:8] == 4'h5) ? ob.ao : (t[11:8] == 4'h6) ? ob.spdif_output_unit : ob.vld;
    if (lit || t[1:0] == 2'h0 || t[1:0] == 2'h3) return {t[1:0] == 2'h3 && (!lit || t[11:8] != 4'h1), w};
    if (t[1:0] == 2'h1) return {1'b0, w[23:16], w[31:24], w[7:0], w[15:8]};
    return {1'b0, w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : expv
  // Main sequence: all big, all little, then a random mix, words back to back
  initial begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    check("reset order", order_state, 33'h0_0000_0000);
    check("reset word", {fmt_error, out_data}, 33'h0_0000_0000);
    check("reset valid", out_valid, 33'h0_0000_0000);
    for (int p = 0; p < 3; p++) begin
      o = (p == 0) ? 7'h00 : (p == 1) ? 7'h7f : 7'($random(seed));
      order_in = o;
      order_load = 1'b1;
      @(negedge clk);
      order_load = 1'b0;
      check("order state", order_state, o);
      for (int i = 0; i < 25; i++) begin
        d = $random(seed);
        in_word = {tbl[i][11:4], d};
        in_valid = 1'b1;
        q.push_back(expv(tbl[i], o, d));
        @(negedge clk);
      end
      in_valid = 1'b0;
    end
    repeat (4) @(negedge clk);
    check("words left", q.size(), 33'h0_0000_0000);
    // Mid-run reset from all little must bring big endian back with no load
    order_in = 7'h7f;
    order_load = 1'b1;
    @(negedge clk);
    order_load = 1'b0;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    check("order after reset", order_state, 33'h0_0000_0000);
    d = $random(seed);
    in_word = {tbl[22][11:4], d};
    in_valid = 1'b1;
    q.push_back(expv(tbl[22], 7'h00, d));
    @(negedge clk);
    in_valid = 1'b0;
    repeat (4) @(negedge clk);
    check("words left after reset", q.size(), 33'h0_0000_0000);
    give_verdict;
  end
  // Result watcher: oldest note against each stored word
  always @(negedge clk) if (got === 1'b1) begin
    exp = (q.size() > 0) ? q.pop_front() : ~got_word;
    check("word", got_word, exp);
  end
  // Hang guard, far above the hundred or so cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      give_verdict;
    end
  end
endmodule : test_media_endian_byte_swapper
